// >>> src/ccpu_top.sv
// Contract
// - Capture copies timer, sets flag, overwrites
// - Mode field selects off/capture/compare/pwm
// - Prescaler cleared when off, non-capture, reset
// - Capture-to-capture switch keeps prescaler count
// - Compare match drives pin, sets flag; the code drives the pin only in set and clear modes, not in trigger mode
// - Control zero forces compare latch low
// - Software-interrupt compare only sets flag
// - Unit one trigger resets capture timer
// - Unit two trigger resets timer, starts conversion
// - Trigger reset never sets overflow flag
// - Pulse-width output with 10-bit duty
// - Control zero forces pwm latch low
// - Period is (period+1)*4*prescale oscillator periods
// - Period match clears timer, sets pin, loads duty; the code leaves the pin low when the new duty is zero
// - Postscaler does not affect pwm frequency
// - Duty is low byte plus control bits 5:4
// - Duty buffered at period match, high read-only
// - Pin clears when buffered duty equals extended timer
// - Duty beyond period never clears pin
//
// Register access over Avalon-MM was chosen for this implementation.
module ccpu_top
   import ccpu_pkg::*;
#(
   parameter int UNITS = 2
) (
   input wire logic sys_clk, // 100 MHz core clock
   input wire logic srst, // Synchronous reset, active high
   input wire logic [9:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data, low byte used
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall until answer ready
   input wire logic [UNITS-1:0] unit_pin_in, // Pin level from pad
   output logic [UNITS-1:0] unit_pin_out, // Output latch level
   output logic [UNITS-1:0] unit_pin_oe_n, // Low while unit drives pin
   output logic conversion_start, // One-cycle converter start
   input wire logic converter_enabled, // Converter is on
   output logic capture_timer_overflow_flag, // Capture timer wrapped
   output logic [UNITS-1:0] unit_event_flag, // Sticky event flags
   output logic period_timer_tick // Period match pulse
);

   ////////////////////////////////////////////////////////////////////
   // Register bus: one wait state, answer on second cycle
   logic ack_ff;
   logic [7:0] idx;
   logic wr_go;
   logic rd_go;
   ccpu_unit_regs_t unit_ff [UNITS];
   logic [UNITS-1:0] flag_ff;
   logic [7:0] period_register_ff;
   logic [7:0] ptimer_ctrl_ff;
   logic [15:0] capture_timer_ff;
   logic [7:0] period_timer_ff;
   logic ovf_ff;
   logic [31:0] rdata_ff;

   assign idx = avs_address[9:2];
   // Writes commit only on the edge that sees waitrequest low
   assign wr_go = avs_write && ack_ff;
   assign rd_go = avs_read && !ack_ff;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
   assign avs_readdata = rdata_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read || avs_write) && !ack_ff;
      end
   end

   function automatic ccpu_kind_t kind_of(input logic [3:0] m);
      if (m == CCPU_MODE_OFF) begin
         return CCPU_KIND_OFF;
      end else if (m[3:2] == 2'b01) begin
         return CCPU_KIND_CAPTURE;
      end else if (m[3:2] == 2'b10) begin
         return CCPU_KIND_COMPARE;
      end else if (m[3:2] == 2'b11 || m[3:2] == 2'b00) begin
         return CCPU_KIND_PWM;
      end
      return CCPU_KIND_OFF;
   endfunction : kind_of

   ////////////////////////////////////////////////////////////////////
   // Timers; the period and capture timers live here as stand-ins
   logic [1:0] quarter_ff;
   logic [3:0] ptpre_ff;
   logic [3:0] ptpre_lim;
   logic pt_inc;
   logic pt_match;
   logic [UNITS-1:0] trig;
   logic ct_inc;
   logic [1:0] frac;
   logic frac_inc;

   // Prescale 1, 4 or 16 selected by control bits 1:0
   assign ptpre_lim = (ptimer_ctrl_ff[1:0] == 2'b00) ? 4'h0 :
                      (ptimer_ctrl_ff[1:0] == 2'b01) ? 4'h3 : 4'hf;
   // One timer step per four oscillator periods times prescale
   assign pt_inc = ptimer_ctrl_ff[2] && (quarter_ff == 2'(CCPU_OSC_PER_TICK - 1))
                   && (ptpre_ff == ptpre_lim);
   assign pt_match = pt_inc && (period_timer_ff == period_register_ff);
   assign period_timer_tick = pt_match;
   assign ct_inc = (quarter_ff == 2'(CCPU_OSC_PER_TICK - 1));
   // Low duty bits step once per prescaled oscillator period
   assign frac = (ptimer_ctrl_ff[1:0] == 2'b00) ? quarter_ff :
                 (ptimer_ctrl_ff[1:0] == 2'b01) ? ptpre_ff[1:0] : ptpre_ff[3:2];
   assign frac_inc = ptimer_ctrl_ff[2] && ((ptimer_ctrl_ff[1:0] == 2'b00) ||
      (quarter_ff == 2'(CCPU_OSC_PER_TICK - 1) &&
       (ptimer_ctrl_ff[1:0] == 2'b01 || ptpre_ff[1:0] == 2'b11)));
   assign capture_timer_overflow_flag = ovf_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         quarter_ff <= 2'h0;
         ptpre_ff <= 4'h0;
      end else begin
         quarter_ff <= quarter_ff + 2'h1;
         if (quarter_ff == 2'(CCPU_OSC_PER_TICK - 1)) begin
            ptpre_ff <= (ptpre_ff == ptpre_lim) ? 4'h0 : ptpre_ff + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         period_timer_ff <= 8'h00;
      end else if (wr_go && idx == CCPU_PTIMER) begin
         period_timer_ff <= avs_writedata[7:0];
      end else if (pt_match) begin
         period_timer_ff <= 8'h00;
      end else if (pt_inc) begin
         period_timer_ff <= period_timer_ff + 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         capture_timer_ff <= 16'h0000;
         ovf_ff <= 1'b0;
      end else begin
         if (|trig) begin
            capture_timer_ff <= 16'h0000;
         end else if (wr_go && idx == CCPU_CTIMER_LOW) begin
            capture_timer_ff[7:0] <= avs_writedata[7:0];
         end else if (wr_go && idx == CCPU_CTIMER_HIGH) begin
            capture_timer_ff[15:8] <= avs_writedata[7:0];
         end else if (ct_inc) begin
            capture_timer_ff <= capture_timer_ff + 16'h0001;
         end
         // Set wins over software clear
         if (ct_inc && !(|trig) && capture_timer_ff == 16'hffff) begin
            ovf_ff <= 1'b1;
         end else if (wr_go && idx == CCPU_FLAGS && avs_writedata[7]) begin
            ovf_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         period_register_ff <= CCPU_PERIOD_RESET;
         ptimer_ctrl_ff <= 8'h00;
      end else if (wr_go && idx == CCPU_PERIOD) begin
         period_register_ff <= avs_writedata[7:0];
      end else if (wr_go && idx == CCPU_TIMER_CTRL) begin
         ptimer_ctrl_ff <= {5'h00, avs_writedata[2:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Per-unit logic, identical for each unit
   logic [UNITS-1:0] pin_s1_ff;
   logic [UNITS-1:0] pin_s2_ff;
   logic [UNITS-1:0] pin_s3_ff;
   logic [UNITS-1:0] latch_ff;
   logic [1:0] duty_lsb_ff [UNITS];
   logic [UNITS-1:0] cap_evt;
   logic [UNITS-1:0] cmp_evt;
   logic [UNITS-1:0] hw_event;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         pin_s3_ff <= '0;
      end else begin
         pin_s1_ff <= unit_pin_in;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end

   for (genvar u = 0; u < UNITS; u++) begin : g_unit
      logic [3:0] mode;
      ccpu_kind_t kind;
      logic rise;
      logic fall;
      logic edge_hit;
      logic [9:0] duty_buf;
      logic [9:0] pt_ext;
      logic [7:0] ctl_idx;
      logic [7:0] low_idx;
      logic [7:0] high_idx;
      logic [3:0] pre_cnt_ff;
      assign ctl_idx = (u == 0) ? CCPU_U1_CONTROL : CCPU_U2_CONTROL;
      assign low_idx = (u == 0) ? CCPU_U1_VALUE_LOW : CCPU_U2_VALUE_LOW;
      assign high_idx = (u == 0) ? CCPU_U1_VALUE_HIGH : CCPU_U2_VALUE_HIGH;
      assign mode = unit_ff[u].ctrl[3:0];
      assign kind = kind_of(mode);
      assign rise = pin_s2_ff[u] && !pin_s3_ff[u];
      assign fall = !pin_s2_ff[u] && pin_s3_ff[u];
      assign edge_hit = (mode == CCPU_MODE_CAP_FALL) ? fall : rise;
      // Prescaler count hit on final edge of the group
      assign cap_evt[u] = (kind == CCPU_KIND_CAPTURE) && edge_hit &&
         ((mode == CCPU_MODE_CAP_RISE4) ? (pre_cnt_ff == CCPU_PS_4) :
          (mode == CCPU_MODE_CAP_RISE16) ? (pre_cnt_ff == CCPU_PS_16) : 1'b1);
      assign cmp_evt[u] = (kind == CCPU_KIND_COMPARE) &&
         (capture_timer_ff == {unit_ff[u].high, unit_ff[u].low});
      assign trig[u] = cmp_evt[u] && (mode == CCPU_MODE_CMP_TRIG);
      assign hw_event[u] = cap_evt[u] || cmp_evt[u];
      assign duty_buf = {unit_ff[u].high, duty_lsb_ff[u]};
      // Next extended count, so the pin drops just as the count reaches duty
      assign pt_ext = {period_timer_ff, frac} + 10'h001;

      always_ff @(posedge sys_clk) begin
         if (srst) begin
            pre_cnt_ff <= 4'h0;
         end else if (kind != CCPU_KIND_CAPTURE) begin
            pre_cnt_ff <= 4'h0;
         end else if (cap_evt[u]) begin
            pre_cnt_ff <= 4'h0;
         end else if (edge_hit) begin
            pre_cnt_ff <= pre_cnt_ff + 4'h1;
         end
      end

      always_ff @(posedge sys_clk) begin
         if (srst) begin
            unit_ff[u] <= '{ctrl: CCPU_CONTROL_RESET, low: 8'h00, high: 8'h00};
            duty_lsb_ff[u] <= 2'h0;
         end else begin
            if (wr_go && idx == ctl_idx) begin
               unit_ff[u].ctrl <= avs_writedata[7:0] & CCPU_CONTROL_MASK;
            end
            if (cap_evt[u]) begin
               unit_ff[u].low <= capture_timer_ff[7:0];
               unit_ff[u].high <= capture_timer_ff[15:8];
            end else begin
               if (wr_go && idx == low_idx) begin
                  unit_ff[u].low <= avs_writedata[7:0];
               end
               if (kind == CCPU_KIND_PWM && pt_match) begin
                  unit_ff[u].high <= unit_ff[u].low;
                  duty_lsb_ff[u] <= unit_ff[u].ctrl[CCPU_DUTY_LSB_POS +: 2];
               end else if (wr_go && idx == high_idx && kind != CCPU_KIND_PWM) begin
                  unit_ff[u].high <= avs_writedata[7:0];
               end
            end
         end
      end

      always_ff @(posedge sys_clk) begin
         if (srst) begin
            latch_ff[u] <= 1'b0;
         end else if (kind == CCPU_KIND_OFF) begin
            latch_ff[u] <= 1'b0;
         end else if (kind == CCPU_KIND_COMPARE) begin
            if (cmp_evt[u] && mode == CCPU_MODE_CMP_SET) begin
               latch_ff[u] <= 1'b1;
            end else if (cmp_evt[u] && mode == CCPU_MODE_CMP_CLR) begin
               latch_ff[u] <= 1'b0;
            end
         end else if (kind == CCPU_KIND_PWM) begin
            if (pt_match) begin
               // Zero duty keeps pin low
               latch_ff[u] <= |{unit_ff[u].low, unit_ff[u].ctrl[5:4]};
            end else if (frac_inc && duty_buf == pt_ext) begin
               latch_ff[u] <= 1'b0;
            end
         end
      end

      // Set wins over clear
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            flag_ff[u] <= 1'b0;
         end else if (hw_event[u]) begin
            flag_ff[u] <= 1'b1;
         end else if (wr_go && idx == CCPU_FLAGS && avs_writedata[u]) begin
            flag_ff[u] <= 1'b0;
         end
      end

      assign unit_pin_oe_n[u] = !(kind == CCPU_KIND_COMPARE || kind == CCPU_KIND_PWM);
   end

   assign unit_pin_out = latch_ff;
   assign unit_event_flag = flag_ff;

   // Conversion start from unit two only
   logic conv_ff;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         conv_ff <= 1'b0;
      end else begin
         conv_ff <= (UNITS > 1) && trig[UNITS-1] && converter_enabled;
      end
   end
   assign conversion_start = conv_ff;

   ////////////////////////////////////////////////////////////////////
   // Read mux; unmapped reads return zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (rd_go) begin
         if (idx == CCPU_U1_CONTROL) begin
            rdata_ff <= {24'h000000, unit_ff[0].ctrl};
         end else if (idx == CCPU_U1_VALUE_LOW) begin
            rdata_ff <= {24'h000000, unit_ff[0].low};
         end else if (idx == CCPU_U1_VALUE_HIGH) begin
            rdata_ff <= {24'h000000, unit_ff[0].high};
         end else if (idx == CCPU_U2_CONTROL && UNITS > 1) begin
            rdata_ff <= {24'h000000, unit_ff[UNITS-1].ctrl};
         end else if (idx == CCPU_U2_VALUE_LOW && UNITS > 1) begin
            rdata_ff <= {24'h000000, unit_ff[UNITS-1].low};
         end else if (idx == CCPU_U2_VALUE_HIGH && UNITS > 1) begin
            rdata_ff <= {24'h000000, unit_ff[UNITS-1].high};
         end else if (idx == CCPU_FLAGS) begin
            rdata_ff <= {24'h000000, ovf_ff, 7'(flag_ff)};
         end else if (idx == CCPU_PERIOD) begin
            rdata_ff <= {24'h000000, period_register_ff};
         end else if (idx == CCPU_TIMER_CTRL) begin
            rdata_ff <= {24'h000000, ptimer_ctrl_ff};
         end else if (idx == CCPU_CTIMER_LOW) begin
            rdata_ff <= {24'h000000, capture_timer_ff[7:0]};
         end else if (idx == CCPU_CTIMER_HIGH) begin
            rdata_ff <= {24'h000000, capture_timer_ff[15:8]};
         end else if (idx == CCPU_PTIMER) begin
            rdata_ff <= {24'h000000, period_timer_ff};
         end else begin
            rdata_ff <= 32'h0000_0000;
         end
      end
   end
endmodule : ccpu_top

// >>> src/ccpu_pkg.sv
package ccpu_pkg;
   // Register indices as printed; byte address is index times four
   localparam logic [7:0] CCPU_U1_VALUE_LOW = 8'h15;
   localparam logic [7:0] CCPU_U1_VALUE_HIGH = 8'h16;
   localparam logic [7:0] CCPU_U1_CONTROL = 8'h17;
   localparam logic [7:0] CCPU_U2_VALUE_LOW = 8'h1b;
   localparam logic [7:0] CCPU_U2_VALUE_HIGH = 8'h1c;
   localparam logic [7:0] CCPU_U2_CONTROL = 8'h1d;
   // Own registers
   localparam logic [7:0] CCPU_FLAGS = 8'h20;
   localparam logic [7:0] CCPU_PERIOD = 8'h21;
   localparam logic [7:0] CCPU_TIMER_CTRL = 8'h22;
   localparam logic [7:0] CCPU_CTIMER_LOW = 8'h23;
   localparam logic [7:0] CCPU_CTIMER_HIGH = 8'h24;
   localparam logic [7:0] CCPU_PTIMER = 8'h25;
   localparam logic [7:0] CCPU_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CCPU_PERIOD_RESET = 8'hff;
   localparam logic [7:0] CCPU_CONTROL_MASK = 8'h3f;
   localparam int CCPU_DUTY_LSB_POS = 4;
   localparam int CCPU_OSC_PER_TICK = 4;
   localparam logic [3:0] CCPU_MODE_OFF = 4'h0;
   localparam logic [3:0] CCPU_MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] CCPU_MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] CCPU_MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] CCPU_MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] CCPU_MODE_CMP_SET = 4'h8;
   localparam logic [3:0] CCPU_MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] CCPU_MODE_CMP_SWI = 4'ha;
   localparam logic [3:0] CCPU_MODE_CMP_TRIG = 4'hb;
   localparam logic [3:0] CCPU_PS_4 = 4'h3;
   localparam logic [3:0] CCPU_PS_16 = 4'hf;

   typedef enum logic [1:0] {
      CCPU_KIND_OFF,
      CCPU_KIND_CAPTURE,
      CCPU_KIND_COMPARE,
      CCPU_KIND_PWM
   } ccpu_kind_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] low;
      logic [7:0] high;
   } ccpu_unit_regs_t;
endpackage : ccpu_pkg

// >>> tb/ccpu_top_properties.sv
module ccpu_top_properties
   import ccpu_pkg::*;
#(
   parameter int UNITS = 2
) (
   input wire logic sys_clk, // Clock
   input wire logic srst, // Reset
   input wire logic [9:0] avs_address, // Address
   input wire logic avs_read, // Read
   input wire logic avs_write, // Write
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [31:0] avs_readdata, // Read data
   input wire logic avs_waitrequest, // Stall
   input wire logic [UNITS-1:0] unit_pin_in, // Pad level
   input wire logic [UNITS-1:0] unit_pin_out, // Latch
   input wire logic [UNITS-1:0] unit_pin_oe_n, // Drive enable
   input wire logic conversion_start, // Start pulse
   input wire logic converter_enabled, // Converter on
   input wire logic capture_timer_overflow_flag, // Overflow
   input wire logic [UNITS-1:0] unit_event_flag, // Flags
   input wire logic period_timer_tick // Tick
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic zero1;
   logic zero2;
   assign zero1 = avs_write && !avs_waitrequest && avs_writedata[7:0] == 8'h00
      && avs_address[9:2] == CCPU_U1_CONTROL;
   assign zero2 = avs_write && !avs_waitrequest && avs_writedata[7:0] == 8'h00
      && avs_address[9:2] == CCPU_U2_CONTROL;
   ////////////////////////////////////////////////////////////////////////////
   a_one_wait_state: assert property ($rose(avs_read || avs_write)
      |-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait state count wrong");
   a_conv_enabled: assert property (conversion_start |-> $past(converter_enabled))
      else $error("conversion start while converter off");
   a_conv_one_cycle: assert property (conversion_start |=> !conversion_start)
      else $error("conversion start longer than one cycle");
   a_tick_one_cycle: assert property (period_timer_tick |=> !period_timer_tick)
      else $error("period tick longer than one cycle");
   a_flag_sticky: assert property (|($past(unit_event_flag) & ~unit_event_flag)
      |-> $past(avs_write)) else $error("event flag fell without a write");
   a_oe_by_write: assert property ($changed(unit_pin_oe_n) |-> $past(avs_write))
      else $error("drive enable moved without a write");
   a_zero_low_one: assert property (zero1 |-> ##2 !unit_pin_out[0] && unit_pin_oe_n[0])
      else $error("unit one latch not forced low");
   a_zero_low_two: assert property (zero2 |-> ##2 !unit_pin_out[1] && unit_pin_oe_n[1])
      else $error("unit two latch not forced low");
   cover property (conversion_start);
   cover property (period_timer_tick);
   cover property ($rose(unit_event_flag[0]));
endmodule : ccpu_top_properties

// >>> tb/ccpu_pin_model.sv
module ccpu_pin_model #(
   parameter int UNITS = 2
) (
   input wire logic [UNITS-1:0] src_lvl, // Level the source drives
   input wire logic [UNITS-1:0] pin_out, // Unit latch
   input wire logic [UNITS-1:0] pin_oe_n, // Low while unit drives
   output logic [UNITS-1:0] pin_in // Resolved pad level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Source backs off while the unit drives, so the pad shows the latch
   assign pin_in = (pin_oe_n & src_lvl) | (~pin_oe_n & pin_out);
endmodule : ccpu_pin_model

// >>> tb/tb_ccpu_top.sv
module tb_ccpu_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ccpu_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [9:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] pin_in, pin_out, pin_oe_n, flags;
   logic [1:0] src_lvl = 2'b00;
   logic conv, ovf, tick, prv;
   logic conv_en = 1'b1;
   logic [7:0] q, b, v, ri[4], rv[4];
   logic [9:0] d;
   int error_cnt = 0;
   int check_count = 0;
   int conv_cnt = 0;
   int hi_cnt = 0;
   int rise_cnt = 0;
   int tick_cnt = 0;
   int u, m, k, p, ps, n, c0, h0, r0, t0, per;
   ccpu_top #(.UNITS(2)) u_ccpu_top (.sys_clk(sys_clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .unit_pin_in(pin_in), .unit_pin_out(pin_out),
      .unit_pin_oe_n(pin_oe_n), .conversion_start(conv), .converter_enabled(conv_en),
      .capture_timer_overflow_flag(ovf), .unit_event_flag(flags), .period_timer_tick(tick));
   ccpu_pin_model #(.UNITS(2)) u_ccpu_pin_model (.src_lvl(src_lvl), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_in(pin_in));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      prv <= pin_out[u];
      conv_cnt <= conv_cnt + int'(conv === 1'b1);
      hi_cnt <= hi_cnt + int'(pin_out[u] === 1'b1);
      rise_cnt <= rise_cnt + int'(pin_out[u] === 1'b1 && prv === 1'b0);
      tick_cnt <= tick_cnt + int'(tick === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] dat);
      int w;
      w = 0;
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, dat};
      do begin
         @(posedge sys_clk);
         w++;
      end while (avs_waitrequest !== 1'b0 && w < 50);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // Two idle edges: next request rises fresh and a write has settled
      repeat (2) @(posedge sys_clk);
      if (w >= 50) error_cnt++;
   endtask : xfer
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic edges(input int n_edges);
      repeat (n_edges) begin
         src_lvl[u] <= 1'b1;
         repeat (8) @(posedge sys_clk);
         src_lvl[u] <= 1'b0;
         repeat (8) @(posedge sys_clk);
      end
   endtask : edges
   task automatic flag_is(input logic exp);
      xfer(1'b0, CCPU_FLAGS, 8'h00);
      chk(q[u], exp);
   endtask : flag_is
   function automatic int exp_hi(int dv, int pv, int sv);
      return ((dv > 4 * (pv + 1)) ? 4 * (pv + 1) : dv) * sv;
   endfunction : exp_hi
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   initial begin
      #500000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h432a));
      u = 0;
      ri = '{CCPU_U1_CONTROL, CCPU_U2_CONTROL, CCPU_PERIOD, 8'h3f};
      rv = '{8'h00, 8'h3f, 8'hff, 8'h00};
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      xfer(1'b1, CCPU_U2_CONTROL, 8'hff);
      foreach (ri[i]) begin
         xfer(1'b0, ri[i], 8'h00);
         chk(q, rv[i]);
      end
      xfer(1'b1, CCPU_U2_CONTROL, 8'h00);
      $display("test registers done");
      for (u = 0; u < 2; u++) begin
         b = u ? CCPU_U2_CONTROL : CCPU_U1_CONTROL;
         for (m = 4; m < 6; m++) begin
            xfer(1'b1, b, 8'(m));
            xfer(1'b1, CCPU_FLAGS, 8'hff);
            edges(1);
            flag_is(1'b1);
         end
         xfer(1'b1, CCPU_CTIMER_HIGH, 8'h00);
         xfer(1'b1, CCPU_CTIMER_LOW, 8'h00);
         xfer(1'b1, b, CCPU_MODE_CAP_RISE4);
         edges(2);
         xfer(1'b1, b, CCPU_MODE_OFF);
         xfer(1'b1, b, CCPU_MODE_CAP_RISE4);
         xfer(1'b1, CCPU_FLAGS, 8'hff);
         edges(3);
         flag_is(1'b0);
         edges(1);
         flag_is(1'b1);
         xfer(1'b0, b - 8'h1, 8'h00);
         chk(q, 8'h00);
         xfer(1'b0, b - 8'h2, 8'h00);
         v = q;
         xfer(1'b0, CCPU_CTIMER_LOW, 8'h00);
         chk(q >= v && q - v < 8'd16, 1'b1);
         xfer(1'b1, CCPU_FLAGS, 8'hff);
         edges(2);
         xfer(1'b1, b, CCPU_MODE_CAP_RISE16);
         xfer(1'b1, CCPU_FLAGS, 8'hff);
         edges(13);
         flag_is(1'b0);
         edges(1);
         flag_is(1'b1);
      end
      $display("test capture done");
      for (k = 0; k < 8; k++) begin
         u = k / 4;
         m = 8 + k % 4;
         b = u ? CCPU_U2_VALUE_LOW : CCPU_U1_VALUE_LOW;
         v = 8'h30 + 8'($urandom_range(31));
         xfer(1'b1, CCPU_U1_CONTROL, 8'h00);
         xfer(1'b1, b + 8'h2, 8'h00);
         chk(pin_out[u], 1'b0);
         xfer(1'b1, b, v);
         xfer(1'b1, b + 8'h1, 8'h00);
         xfer(1'b1, CCPU_CTIMER_HIGH, 8'h00);
         xfer(1'b1, CCPU_CTIMER_LOW, 8'h00);
         xfer(1'b1, CCPU_FLAGS, 8'hff);
         c0 = conv_cnt;
         xfer(1'b1, b + 8'h2, 8'(m));
         n = 0;
         do begin
            xfer(1'b0, CCPU_FLAGS, 8'h00);
            n++;
         end while (q[u] !== 1'b1 && n < 200);
         chk(q[u], 1'b1);
         chk(q[7], 1'b0);
         chk(pin_out[u], m == 8);
         chk(pin_oe_n[u], 1'b0);
         xfer(1'b0, CCPU_CTIMER_LOW, 8'h00);
         if (m == 11) chk(q < v, 1'b1);
         chk(conv_cnt != c0, u == 1 && m == 11);
         chk(ovf, 1'b0);
      end
      // Unit two still triggers; a disabled converter must not start
      conv_en <= 1'b0;
      c0 = conv_cnt;
      repeat (800) @(posedge sys_clk);
      chk(conv_cnt != c0, 1'b0);
      conv_en <= 1'b1;
      $display("test compare done");
      for (k = 0; k < 6; k++) begin
         u = k % 2;
         ps = k / 3;
         b = u ? CCPU_U2_VALUE_LOW : CCPU_U1_VALUE_LOW;
         p = 3 + $urandom_range(5);
         per = 4 * (p + 1) * (ps ? 4 : 1);
         d = (k % 3 == 0) ? 10'(1 + $urandom_range(4 * p + 2)) :
            (k % 3 == 1) ? 10'h000 : 10'(4 * p + 5 + $urandom_range(20));
         xfer(1'b1, CCPU_PERIOD, 8'(p));
         xfer(1'b1, CCPU_PTIMER, 8'h00);
         xfer(1'b1, b, d[9:2]);
         xfer(1'b1, b + 8'h2, {2'b00, d[1:0], 4'h0});
         xfer(1'b1, CCPU_TIMER_CTRL, {5'b00000, 1'b1, 2'(ps)});
         xfer(1'b1, b + 8'h2, {2'b00, d[1:0], 2'b11, 2'(k)});
         repeat (2 * per + 8) @(posedge sys_clk);
         h0 = hi_cnt;
         r0 = rise_cnt;
         t0 = tick_cnt;
         repeat (3 * per) @(posedge sys_clk);
         chk(16'(hi_cnt - h0), 16'(3 * exp_hi(d, p, ps ? 4 : 1)));
         chk(16'(rise_cnt - r0), (d > 0 && d < 4 * (p + 1)) ? 16'h3 : 16'h0);
         chk(16'(tick_cnt - t0), 16'h3);
         xfer(1'b1, b + 8'h1, ~d[9:2]);
         xfer(1'b0, b + 8'h1, 8'h00);
         chk(q, d[9:2]);
         xfer(1'b1, b + 8'h2, 8'h00);
         chk(pin_out[u], 1'b0);
      end
      $display("test pwm done");
      tally_and_finish();
   end
endmodule : tb_ccpu_top
bind ccpu_top ccpu_top_properties #(.UNITS(UNITS)) u_ccpu_top_properties (
   .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .unit_pin_in(unit_pin_in),
   .unit_pin_out(unit_pin_out), .unit_pin_oe_n(unit_pin_oe_n),
   .conversion_start(conversion_start), .converter_enabled(converter_enabled),
   .capture_timer_overflow_flag(capture_timer_overflow_flag),
   .unit_event_flag(unit_event_flag), .period_timer_tick(period_timer_tick));
